// [rgbs_readout.v]
// Gated integration and serial readout of a three-colour light sensor
`timescale 1ns/1ps
`include "rgbs_map.vh"
module rgbs_readout #(
  parameter CNT_W = `RGBS_CNT_W
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // Controller pins
  input  wire       range_sel,
  input  wire       gate,
  input  wire       shift_clock,
  output wire       dout,
  // Light-to-frequency pulses, full array and centre group
  input  wire [2:0] freq_full,
  input  wire [2:0] freq_centre,
  // Status
  output wire       integrating,
  output wire       result_ready,
  output wire       range_used
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_INTEG = 2'h1;
  localparam ST_SHIFT = 2'h2;

  reg [1:0]       state_reg;
  reg [1:0]       gate_sync_reg;
  reg [1:0]       clk_sync_reg;
  reg [1:0]       range_sync_reg;
  reg [2:0]       full_sync1_reg;
  reg [2:0]       full_sync2_reg;
  reg [2:0]       ctr_sync1_reg;
  reg [2:0]       ctr_sync2_reg;
  reg             gate_d_reg;
  reg             clk_d_reg;
  reg [2:0]       freq_d_reg;
  reg             range_reg;
  reg [CNT_W-1:0] cnt_reg [0:2];
  reg [3*CNT_W-1:0] shift_reg;
  reg [5:0]       bit_cnt_reg;
  reg             dout_reg;
  reg             load_pend_reg;
  wire            gate_rise;
  wire            gate_fall;
  wire            clk_rise;
  wire [2:0]      freq_sel;
  wire [2:0]      freq_edge;
  wire            buf_in_ready;
  wire            buf_out_valid;
  wire [3*CNT_W-1:0] buf_out_data;
  wire            buf_take;
  // Readout sequencing
  wire            buf_load;
  wire            start_integ;
  wire            shift_step;
  wire            last_bit;
  integer         i;

  // Saturating increment
  function [CNT_W-1:0] sat_inc;
    input [CNT_W-1:0] v;
    begin
      if (v == `RGBS_CNT_MAX) begin
        sat_inc = v;
      end else begin
        sat_inc = v + `RGBS_CNT_ONE;
      end
    end
  endfunction

  assign gate_rise = gate_sync_reg[1] & ~gate_d_reg;
  assign gate_fall = ~gate_sync_reg[1] & gate_d_reg;
  assign clk_rise  = clk_sync_reg[1] & ~clk_d_reg;
  assign freq_sel  = range_reg ? full_sync2_reg : ctr_sync2_reg;
  assign freq_edge = freq_sel & ~freq_d_reg;
  // A new gate rise wins over a readout in progress
  assign start_integ = gate_rise && !load_pend_reg &&
                       ((state_reg == ST_IDLE) || (state_reg == ST_SHIFT));
  assign last_bit    = (bit_cnt_reg == `RGBS_BITS_TOTAL - `RGBS_BIT_ONE);
  assign shift_step  = (state_reg == ST_SHIFT) && clk_rise && !gate_rise;
  // The queue head is dropped only once all its bits went out
  assign buf_load    = buf_out_valid && (state_reg == ST_IDLE) && !gate_sync_reg[1];
  assign buf_take    = shift_step && last_bit;

  assign dout         = dout_reg;
  assign integrating  = (state_reg == ST_INTEG);
  assign result_ready = buf_out_valid;
  assign range_used   = range_reg;

  // Result words queue here, so a slow or absent readout loses no measurement
  rgbs_buf2 #(
    .WIDTH (3*CNT_W)
  ) u_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (load_pend_reg),
    .in_ready  (buf_in_ready),
    .in_data   ({cnt_reg[2], cnt_reg[1], cnt_reg[0]}),
    .out_valid (buf_out_valid),
    .out_ready (buf_take),
    .out_data  (buf_out_data)
  );

  // Pin synchronisers
  always @(posedge clk) begin
    if (!rst_b) begin
      gate_sync_reg  <= 2'h0;
      clk_sync_reg   <= 2'h0;
      range_sync_reg <= 2'h0;
      full_sync1_reg <= 3'h0;
      full_sync2_reg <= 3'h0;
      ctr_sync1_reg  <= 3'h0;
      ctr_sync2_reg  <= 3'h0;
      gate_d_reg     <= 1'b0;
      clk_d_reg      <= 1'b0;
      freq_d_reg     <= 3'h0;
    end else begin
      gate_sync_reg  <= {gate_sync_reg[0], gate};
      clk_sync_reg   <= {clk_sync_reg[0], shift_clock};
      range_sync_reg <= {range_sync_reg[0], range_sel};
      full_sync1_reg <= freq_full;
      full_sync2_reg <= full_sync1_reg;
      ctr_sync1_reg  <= freq_centre;
      ctr_sync2_reg  <= ctr_sync1_reg;
      gate_d_reg     <= gate_sync_reg[1];
      clk_d_reg      <= clk_sync_reg[1];
      freq_d_reg     <= freq_sel;
    end
  end

  // Integration and readout state
  always @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else if (start_integ) begin
      state_reg <= ST_INTEG;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (buf_load) begin
            state_reg <= ST_SHIFT;
          end
        end
        ST_INTEG: begin
          if (gate_fall) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_SHIFT: begin
          // An abandoned readout keeps its word queued for a later read
          if (gate_rise) begin
            state_reg <= ST_IDLE;
          end else if (buf_take) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Sensitivity is taken once per measurement, at the gate rise
  always @(posedge clk) begin
    if (!rst_b) begin
      range_reg <= 1'b0;
    end else if (start_integ) begin
      range_reg <= range_sync_reg[1];
    end
  end

  // Colour counters; counting stops with the gate, so results hold
  always @(posedge clk) begin
    if (!rst_b) begin
      for (i = 0; i < 3; i = i + 1) begin
        cnt_reg[i] <= `RGBS_CNT_ZERO;
      end
    end else if (start_integ) begin
      for (i = 0; i < 3; i = i + 1) begin
        cnt_reg[i] <= `RGBS_CNT_ZERO;
      end
    end else if (state_reg == ST_INTEG) begin
      for (i = 0; i < 3; i = i + 1) begin
        if (freq_edge[i]) begin
          cnt_reg[i] <= sat_inc(cnt_reg[i]);
        end
      end
    end
  end

  // Finished measurement waiting for room in the queue
  // Setting wins over clearing, so a result is never lost
  always @(posedge clk) begin
    if (!rst_b) begin
      load_pend_reg <= 1'b0;
    end else if ((state_reg == ST_INTEG) && gate_fall) begin
      load_pend_reg <= 1'b1;
    end else if (load_pend_reg && buf_in_ready) begin
      load_pend_reg <= 1'b0;
    end
  end

  // Serial shifter: loads the queue head, moves one bit per link clock rise
  always @(posedge clk) begin
    if (!rst_b) begin
      shift_reg   <= {3*CNT_W{1'b0}};
      bit_cnt_reg <= `RGBS_BIT_ZERO;
      dout_reg    <= 1'b0;
    end else if (buf_load) begin
      shift_reg   <= buf_out_data;
      bit_cnt_reg <= `RGBS_BIT_ZERO;
    end else if (shift_step) begin
      // LSB of red first, then green, then blue
      dout_reg    <= shift_reg[0];
      shift_reg   <= {1'b0, shift_reg[3*CNT_W-1:1]};
      bit_cnt_reg <= bit_cnt_reg + `RGBS_BIT_ONE;
    end
  end
endmodule

// [rgbs_map.vh]
// Constants for the gated three-colour serial readout
// Operation
// - Inputs are range, gate and shift clock
// - Gate rising edge starts integration; ignored while a finished result waits for room in the queue
// - Gate falling edge ends integration, keeps results
// - Thirty-six shift pulses, one bit each
// - Red, then green, then blue, twelve each
// - Each colour shifted out LSB first
// - Output changes only on shift rising edge
// - Count pulses while gate high, hold result
// - Twelve-bit counts emitted red, green, blue
// - Range high full array, low centre group
`ifndef RGBS_MAP_VH
`define RGBS_MAP_VH
`define RGBS_CNT_W       12
`define RGBS_CNT_MAX     12'hfff
`define RGBS_CNT_ZERO    12'h000
`define RGBS_BITS_TOTAL  6'h24
`define RGBS_BIT_ZERO    6'h00
`define RGBS_BIT_ONE     6'h01
`define RGBS_GRN_FIRST   6'h0c
`define RGBS_BLU_FIRST   6'h18
`define RGBS_CLR_RED     2'h0
`define RGBS_CLR_GRN     2'h1
`define RGBS_CLR_BLU     2'h2
`define RGBS_CNT_ONE     12'h001
`endif

// [rgbs_buf2.v]
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module rgbs_buf2 #(
  parameter WIDTH = 36
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // Filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg             wr_ptr_reg;
  reg             rd_ptr_reg;
  reg [1:0]       count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
      mem_reg[0] <= {WIDTH{1'b0}};
      mem_reg[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule

// [rgbs_readout_props.sv]
// Checker for the three-colour serial readout
`timescale 1ns/1ps
module rgbs_readout_props #(
  parameter CNT_W = 12
) (
  // Observed ports
  input wire       clk,
  input wire       rst_b,
  input wire       range_sel,
  input wire       gate,
  input wire       shift_clock,
  input wire       dout,
  input wire [2:0] freq_full,
  input wire [2:0] freq_centre,
  input wire       integrating,
  input wire       result_ready,
  input wire       range_used
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  rst_clear_a: assert property (disable iff (1'b0) !rst_b |=>
    !integrating && !result_ready && !dout && !range_used) else $error("reset");
  start_gate_a: assert property ($rose(integrating) |-> gate && $past(gate, 2))
    else $error("start");
  end_gate_a: assert property (!gate [*7] |-> !integrating) else $error("end");
  latch_rng_a: assert property ($rose(integrating) |=> range_used == range_sel)
    else $error("range");
  hold_rng_a: assert property ($past(integrating) && integrating |=> $stable(range_used))
    else $error("hold");
  dout_edge_a: assert property ($changed(dout) |->
    $past(shift_clock, 2) || $past(shift_clock, 3)) else $error("dout");
  result_push_a: assert property ($fell(integrating) |-> ##[1:4] result_ready)
    else $error("push");
  early_ready_a: assert property (integrating |-> !$rose(result_ready))
    else $error("ready");
  cover property ($fell(integrating));
  cover property ($changed(dout));
  cover property ($rose(integrating) && result_ready);
endmodule
bind rgbs_readout rgbs_readout_props #(.CNT_W(CNT_W)) i_props (.clk(clk), .rst_b(rst_b),
  .range_sel(range_sel), .gate(gate), .shift_clock(shift_clock), .dout(dout),
  .freq_full(freq_full), .freq_centre(freq_centre), .integrating(integrating),
  .result_ready(result_ready), .range_used(range_used));

// [rgbs_ctrl_model.sv]
// Controller model driving range, gate and shift clock
`timescale 1ns/1ps
module rgbs_ctrl_model (
  // Clock
  input  wire clk,
  // Sensor pins
  output reg  range_sel,
  output reg  gate,
  output reg  shift_clock,
  input  wire dout
);
  integer k;
  initial begin
    range_sel = 1'b0;
    gate = 1'b0;
    shift_clock = 1'b0;
  end
  task start(input r);
    begin
      @(posedge clk) range_sel <= r;
      repeat (6) @(posedge clk);
      gate <= 1'b1;
    end
  endtask
  task stop;
    begin
      @(posedge clk) gate <= 1'b0;
    end
  endtask
  // Link clock runs only within a readout, 320 ns period, low between frames
  task read(output [35:0] w);
    begin
      repeat (8) @(posedge clk);
      for (k = 0; k < 36; k = k + 1) begin
        shift_clock <= 1'b1;
        repeat (4) @(posedge clk);
        shift_clock <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk) w[k] = dout;
        @(posedge clk);
      end
    end
  endtask
endmodule

// [rgb_gated_serial_readout_tb.sv]
// Self-checking bench for the three-colour serial readout
`timescale 1ns/1ps
module rgb_gated_serial_readout_tb;
  reg         clk;
  reg         rst_b;
  reg  [2:0]  freq_full;
  reg  [2:0]  freq_centre;
  reg  [35:0] got, exp0, exp1;
  wire        range_sel, gate, shift_clock, dout;
  wire [2:0]  status;
  integer     err_count, check_count, seed, i;
  rgbs_readout i_dut (.clk(clk), .rst_b(rst_b), .range_sel(range_sel), .gate(gate),
    .shift_clock(shift_clock), .dout(dout), .freq_full(freq_full),
    .freq_centre(freq_centre), .integrating(status[2]), .result_ready(status[1]),
    .range_used(status[0]));
  rgbs_ctrl_model i_ctl (.clk(clk), .range_sel(range_sel), .gate(gate),
    .shift_clock(shift_clock), .dout(dout));
  function [11:0] sat_inc(input [11:0] v);
    sat_inc = (v == 12'hfff) ? v : v + 12'h001;
  endfunction
  task check(input [35:0] seen, input [35:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want) begin
        err_count = err_count + 1;
        $display("CHECK FAILED result expected %h seen %h", want, seen);
      end
      $display("test %0d done", check_count);
    end
  endtask
  // Status outputs: integrating, result queued, range in use
  task stat_check(input [2:0] want);
    begin
      @(negedge clk);
      check({33'h0, status}, {33'h0, want});
    end
  endtask
  // Pulses stay well inside the gate so sync delays cannot cut one off
  task integ(input r, input integer n, output [35:0] e);
    reg [31:0] rnd;
    integer    k, b;
    begin
      e = 36'h0;
      i_ctl.start(r);
      repeat (8) @(posedge clk);
      for (k = 0; k < n; k = k + 1) begin
        rnd = $random(seed);
        freq_full <= rnd[2:0] | {3{n > 4000}};
        freq_centre <= rnd[5:3];
        for (b = 0; b < 3; b = b + 1)
          if (r ? (rnd[b] || n > 4000) : rnd[b + 3]) e[b * 12 +: 12] = sat_inc(e[b * 12 +: 12]);
        repeat (2) @(posedge clk);
        freq_full <= 3'h0;
        freq_centre <= 3'h0;
        repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      i_ctl.stop;
      repeat (12) @(posedge clk);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #2000000;
    err_count = err_count + 1;
    close_out;
  end
  initial begin
    seed = 32'h933d;
    err_count = 0;
    check_count = 0;
    rst_b = 1'b0;
    freq_full = 3'h0;
    freq_centre = 3'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    integ(1'b1, 4100, exp0);
    stat_check(3'b011);
    i_ctl.read(got);
    check(got, exp0);
    for (i = 0; i < 4; i = i + 1) begin
      integ(i[0], i * 90, exp0);
      stat_check({2'b01, i[0]});
      i_ctl.read(got);
      check(got, exp0);
    end
    integ(1'b0, 40, exp0);
    integ(1'b1, 60, exp1);
    stat_check(3'b011);
    i_ctl.read(got);
    check(got, exp0);
    stat_check(3'b011);
    i_ctl.read(got);
    check(got, exp1);
    stat_check(3'b001);
    close_out;
  end
endmodule
